/* File: shared/dvtd_pkg.sv */
// Constants, register layout and types for the duty-to-voltage target block
//
// Operation
// - Bit 15 of the transition control register picks comparison of target against reference (0) or on-time change (1) as the transition trigger.
// - Bit 14 of the transition control register enables the slow filter synchronising function.
// - With synchronising enabled and a non-zero interval, a slow filter hysteresis output unchanged for the whole check interval is loaded with its input.
// - A transition is classed downward when the reference exceeds the target plus the 4-bit threshold at bits 13:10.
// - A transition is classed upward when the reference is below the target minus the 4-bit threshold at bits 9:6.
// - Settled in on-time mode, an on-time drop above the 3-bit threshold at bits 5:3 (5 ns steps) starts a downward transition.
// - Settled in on-time mode, an on-time rise above the 3-bit threshold at bits 2:0 (5 ns steps) starts an upward transition.
// - Settled uses the slow filter result as reference, and any transition switches it to the fast filter result.
// - Gain register bits 15:11 ignore writes and read as zero.
// - The target code is the measured on-time times the gain plus the minimum output code.
// - Settled in comparison mode, target below reference minus start-down threshold goes down and above reference plus start-up threshold goes up.
// - In a downward transition, reference below target plus the end threshold returns the reference to the slow filter.
// - The synchronising check interval is a 5-bit field in 100 us steps.
package dvtd_pkg;

    // ----------------------------------------------------------------
    // Register command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_START_CONTROL = 8'hb1;
    localparam logic [7:0] CMD_TRANSITION_CONTROL = 8'hb2;
    localparam logic [7:0] CMD_GAIN = 8'hb3;
    localparam logic [7:0] CMD_FLOOR = 8'hb4;

    localparam logic [15:0] RESET_CONTROL = 16'h0000;
    localparam logic [15:0] RESET_GAIN = 16'h0000;
    localparam logic [15:0] RESET_FLOOR = 16'h0000;
    localparam logic [15:0] GAIN_FIELD_MASK = 16'h07ff;

    // ----------------------------------------------------------------
    // Widths and timing
    // ----------------------------------------------------------------
    localparam int CODE_W = 16;
    localparam int GAIN_W = 11;
    localparam int GAIN_FRAC = 9;
    localparam int CLK_PERIOD_NS = 25;
    localparam int ONTIME_LSB_NS = 5;
    localparam logic [15:0] ONTIME_INC = 16'(CLK_PERIOD_NS / ONTIME_LSB_NS);
    localparam logic [15:0] ONTIME_MAX = 16'hffff;
    localparam int CHECK_STEP_US = 100;
    localparam int CHECK_STEP_CYC = CHECK_STEP_US * 1000 / CLK_PERIOD_NS;
    localparam logic [15:0] HYST_BAND = 16'h0002;

    // ----------------------------------------------------------------
    // Field layouts
    // ----------------------------------------------------------------
    typedef struct packed {
        logic trig_by_ontime;
        logic slow_filter_sync_enable;
        logic [3:0] down_direction_threshold;
        logic [3:0] up_direction_threshold;
        logic [2:0] ontime_drop_threshold;
        logic [2:0] ontime_rise_threshold;
    } dvtd_ctrl_t;

    typedef struct packed {
        logic [2:0] down_start_threshold;
        logic [2:0] up_start_threshold;
        logic [2:0] down_end_threshold;
        logic [4:0] sync_check_interval;
        logic [1:0] slow_average_window;
    } dvtd_start_t;

    typedef struct packed {
        logic [CODE_W-1:0] fast_code;
        logic [CODE_W-1:0] slow_code;
        logic [CODE_W-1:0] min_output_code;
    } dvtd_codes_t;

    typedef enum logic [1:0] {
        ST_SETTLED,
        ST_DOWN,
        ST_UP
    } dvtd_state_t;

endpackage : dvtd_pkg

/* File: hdl/dvtd_slow_hyst.sv */
// Hysteresis stage on the slow filter output with its synchronising option
`timescale 1ns/10ps
module dvtd_slow_hyst
    import dvtd_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic [CODE_W-1:0] i_code,
    input wire logic i_sync_en,
    input wire logic [4:0] i_check_steps,
    output logic [CODE_W-1:0] o_code
);

    logic [CODE_W-1:0] out_reg;
    logic [16:0] idle_cnt_reg;
    logic [16:0] idle_cnt_next;
    wire [CODE_W-1:0] diff = (i_code > out_reg) ? i_code - out_reg
                                                : out_reg - i_code;
    wire jump = diff > HYST_BAND;
    // Zero interval means no synchronising; the wrapped limit would otherwise copy every 131072 cycles
    wire [16:0] limit = 17'(i_check_steps * CHECK_STEP_CYC);
    wire sync_hit = i_sync_en && (i_check_steps != 5'h0)
                    && (idle_cnt_reg >= limit - 17'h1);

    assign idle_cnt_next = (jump || sync_hit || !i_sync_en) ? 17'h0
                           : idle_cnt_reg + 17'h1;

    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            out_reg <= '0;
            idle_cnt_reg <= '0;
        end
        else
        begin
            if (jump || sync_hit)
                out_reg <= i_code;
            idle_cnt_reg <= idle_cnt_next;
        end
    end

    assign o_code = out_reg;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    a_sync_copy_out: assert property (
        sync_hit |=> o_code == $past(i_code))
        else $error("Hysteresis output not synchronised at interval end");
    a_sync_off_hold: assert property (
        (!i_sync_en && !jump) |=> $stable(o_code))
        else $error("Hysteresis output moved inside band with sync off");
    c_sync_event: cover property (sync_hit && o_code != i_code);

endmodule : dvtd_slow_hyst

/* File: hdl/dvtd_target_detect.sv */
// Duty command to target code, transition detection and reference choice
`timescale 1ns/10ps
module dvtd_target_detect
    import dvtd_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_duty_voltage_command,
    input wire logic [CODE_W-1:0] i_fast_filter_code,
    input wire logic [CODE_W-1:0] i_slow_filter_code,
    input wire logic [CODE_W-1:0] i_min_output_code,
    input wire logic [7:0] i_reg_cmd,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [15:0] i_reg_wdata,
    output logic [15:0] o_reg_rdata,
    output logic o_reg_ack,
    output logic [CODE_W-1:0] o_target_voltage_code,
    output logic [CODE_W-1:0] o_output_reference,
    output logic o_transition_active,
    output logic o_transition_down,
    output logic o_direction_down,
    output logic o_direction_up
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [16:0] f_add(input logic [CODE_W-1:0] a,
                                          input logic [CODE_W-1:0] b);
        f_add = {1'b0, a} + {1'b0, b};
    endfunction : f_add

    function automatic logic [CODE_W-1:0] f_target(
        input logic [15:0] ontime, input logic [GAIN_W-1:0] gain,
        input logic [CODE_W-1:0] min_code);
        logic [26:0] prod;
        logic [18:0] sum;
        prod = {11'h0, ontime} * {16'h0, gain};
        sum = {1'b0, prod[26:GAIN_FRAC]} + {3'h0, min_code};
        // Saturate rather than wrap to a low code on overflow
        f_target = (sum > 19'h0ffff) ? '1 : sum[CODE_W-1:0];
    endfunction : f_target

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    dvtd_ctrl_t ctrl_reg;
    dvtd_start_t start_reg;
    logic [GAIN_W-1:0] gain_reg;
    logic [15:0] floor_reg;
    logic [15:0] rdata_reg;
    logic ack_reg;
    logic [15:0] rdata_next;

    wire wr_ctrl = i_reg_wr && (i_reg_cmd == CMD_TRANSITION_CONTROL);
    wire wr_start = i_reg_wr && (i_reg_cmd == CMD_START_CONTROL);
    wire wr_gain = i_reg_wr && (i_reg_cmd == CMD_GAIN);
    wire wr_floor = i_reg_wr && (i_reg_cmd == CMD_FLOOR);

    always_comb
    begin
        case (i_reg_cmd)
            CMD_START_CONTROL: rdata_next = start_reg;
            CMD_TRANSITION_CONTROL: rdata_next = ctrl_reg;
            CMD_GAIN: rdata_next = {5'h0, gain_reg};
            CMD_FLOOR: rdata_next = floor_reg;
            default: rdata_next = 16'h0000;
        endcase
    end

    // Floor parameter is held for the downstream filters, not used here
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ctrl_reg <= RESET_CONTROL;
            start_reg <= RESET_CONTROL;
            gain_reg <= RESET_GAIN[GAIN_W-1:0];
            floor_reg <= RESET_FLOOR;
            rdata_reg <= '0;
            ack_reg <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_reg <= i_reg_wdata;
            if (wr_start)
                start_reg <= i_reg_wdata;
            if (wr_gain)
                gain_reg <= i_reg_wdata[GAIN_W-1:0];
            if (wr_floor)
                floor_reg <= i_reg_wdata;
            if (i_reg_rd)
                rdata_reg <= rdata_next;
            ack_reg <= i_reg_rd || i_reg_wr;
        end
    end

    assign o_reg_rdata = rdata_reg;
    assign o_reg_ack = ack_reg;

    // ----------------------------------------------------------------
    // On-time measurement
    // ----------------------------------------------------------------
    logic pwm_meta_reg;
    logic pwm_sync_reg;
    logic pwm_last_reg;
    logic [15:0] count_reg;
    logic [15:0] ontime_reg;
    logic [15:0] prev_ontime_reg;
    logic meas_reg;

    wire pwm_fall = pwm_last_reg && !pwm_sync_reg;
    // Long highs clamp instead of wrapping back to a short on-time
    wire [15:0] count_next = !pwm_sync_reg ? 16'h0
        : (count_reg > ONTIME_MAX - ONTIME_INC) ? ONTIME_MAX
        : count_reg + ONTIME_INC;

    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pwm_meta_reg <= 1'b0;
            pwm_sync_reg <= 1'b0;
            pwm_last_reg <= 1'b0;
            count_reg <= '0;
            ontime_reg <= '0;
            prev_ontime_reg <= '0;
            meas_reg <= 1'b0;
        end
        else
        begin
            pwm_meta_reg <= i_duty_voltage_command;
            pwm_sync_reg <= pwm_meta_reg;
            pwm_last_reg <= pwm_sync_reg;
            count_reg <= count_next;
            meas_reg <= pwm_fall;
            if (pwm_fall)
            begin
                ontime_reg <= count_reg;
                prev_ontime_reg <= ontime_reg;
            end
        end
    end

    // ----------------------------------------------------------------
    // Target, slow path and decisions
    // ----------------------------------------------------------------
    logic [CODE_W-1:0] slow_code;
    dvtd_codes_t codes;
    assign codes = '{fast_code: i_fast_filter_code,
                     slow_code: i_slow_filter_code,
                     min_output_code: i_min_output_code};

    dvtd_slow_hyst u_slow_hyst (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_code(codes.slow_code),
        .i_sync_en(ctrl_reg.slow_filter_sync_enable),
        .i_check_steps(start_reg.sync_check_interval),
        .o_code(slow_code)
    );

    dvtd_state_t state_reg;
    dvtd_state_t state_next;
    logic [CODE_W-1:0] target_reg;
    logic [CODE_W-1:0] ref_reg;
    logic dir_down_reg;
    logic dir_up_reg;

    wire [CODE_W-1:0] target =
        f_target(ontime_reg, gain_reg, codes.min_output_code);
    wire [16:0] ref_wide = {1'b0, ref_reg};
    wire [16:0] tgt_wide = {1'b0, target};
    wire cmp_down = f_add(target,
        16'(start_reg.down_start_threshold)) < ref_wide;
    wire cmp_up = tgt_wide > f_add(ref_reg,
        16'(start_reg.up_start_threshold));
    wire on_drop = (prev_ontime_reg > ontime_reg) &&
        (prev_ontime_reg - ontime_reg > 16'(ctrl_reg.ontime_drop_threshold));
    wire on_rise = (ontime_reg > prev_ontime_reg) &&
        (ontime_reg - prev_ontime_reg > 16'(ctrl_reg.ontime_rise_threshold));
    wire go_down = ctrl_reg.trig_by_ontime ? on_drop : cmp_down;
    wire go_up = ctrl_reg.trig_by_ontime ? on_rise : cmp_up;
    wire end_down = ref_wide < f_add(target,
        16'(start_reg.down_end_threshold));
    // Upward end mirrors the downward one with the same band
    wire end_up = f_add(ref_reg,
        16'(start_reg.down_end_threshold)) > tgt_wide;
    wire is_down_dir = ref_wide > f_add(target,
        16'(ctrl_reg.down_direction_threshold));
    wire is_up_dir = f_add(ref_reg,
        16'(ctrl_reg.up_direction_threshold)) < tgt_wide;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_SETTLED:
            begin
                if (meas_reg && go_down)
                    state_next = ST_DOWN;
                else if (meas_reg && go_up)
                    state_next = ST_UP;
            end
            ST_DOWN:
            begin
                if (meas_reg && end_down)
                    state_next = ST_SETTLED;
            end
            ST_UP:
            begin
                if (meas_reg && end_up)
                    state_next = ST_SETTLED;
            end
            default: state_next = ST_SETTLED;
        endcase
    end

    wire [CODE_W-1:0] ref_next = (state_next == ST_SETTLED) ? slow_code
                                 : codes.fast_code;

    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_reg <= ST_SETTLED;
            target_reg <= '0;
            ref_reg <= '0;
            dir_down_reg <= 1'b0;
            dir_up_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            ref_reg <= ref_next;
            if (meas_reg)
            begin
                target_reg <= target;
                dir_down_reg <= is_down_dir;
                dir_up_reg <= is_up_dir;
            end
        end
    end

    assign o_target_voltage_code = target_reg;
    assign o_output_reference = ref_reg;
    assign o_transition_active = (state_reg != ST_SETTLED);
    assign o_transition_down = (state_reg == ST_DOWN);
    assign o_direction_down = dir_down_reg;
    assign o_direction_up = dir_up_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    a_gain_reserved_zero: assert property (
        (i_reg_rd && i_reg_cmd == CMD_GAIN) |=> o_reg_rdata[15:11] == 5'h0)
        else $error("Gain reserved bits read non-zero");
    a_target_formula: assert property (
        meas_reg |=> o_target_voltage_code ==
            f_target($past(ontime_reg), $past(gain_reg),
                     $past(i_min_output_code)))
        else $error("Target code does not follow on-time times gain");
    a_ontime_drop_down: assert property (
        (meas_reg && state_reg == ST_SETTLED && ctrl_reg.trig_by_ontime
         && on_drop) |=> o_transition_down)
        else $error("On-time drop did not start downward transition");
    a_ontime_rise_up: assert property (
        (meas_reg && state_reg == ST_SETTLED && ctrl_reg.trig_by_ontime
         && !on_drop && on_rise) |=> state_reg == ST_UP)
        else $error("On-time rise did not start upward transition");
    a_compare_trigger: assert property (
        (meas_reg && state_reg == ST_SETTLED && !ctrl_reg.trig_by_ontime
         && !cmp_down && !cmp_up) |=> !o_transition_active)
        else $error("Comparison mode started transition without cause");
    a_down_end_back: assert property (
        (meas_reg && state_reg == ST_DOWN && end_down)
        |=> !o_transition_active ##0 o_output_reference == $past(slow_code))
        else $error("Downward transition did not end on threshold");
    a_ref_fast_trans: assert property (
        o_transition_active |-> o_output_reference == $past(i_fast_filter_code))
        else $error("Reference not on fast filter during transition");
    a_ontime_counts: assert property (
        (pwm_sync_reg && pwm_last_reg && count_reg < 16'h00ff)
        |=> count_reg == $past(count_reg) + ONTIME_INC)
        else $error("On-time count not advancing by 5 ns units");
    a_hold_no_meas: assert property (
        !meas_reg |=> $stable(state_reg) && $stable(o_target_voltage_code))
        else $error("Decision changed without new measurement");

    c_enter_down: cover property (
        state_reg == ST_SETTLED ##1 state_reg == ST_DOWN);
    c_enter_up_ontime: cover property (
        ctrl_reg.trig_by_ontime && state_reg == ST_SETTLED
        ##1 state_reg == ST_UP);
    c_down_round: cover property (
        state_reg == ST_DOWN ##1 state_reg == ST_SETTLED);
    c_gain_read: cover property (i_reg_rd && i_reg_cmd == CMD_GAIN);

endmodule : dvtd_target_detect

/* File: verification/dvtd_cmd_source.sv */
// Behavioural processor side that drives the duty voltage command pin
`timescale 1ns/10ps
module dvtd_cmd_source
(
    input wire logic i_core_clk,
    input wire logic i_go,
    input wire logic [15:0] i_high_cycles,
    input wire logic [15:0] i_low_cycles,
    output logic o_pin,
    output logic o_done
);
    // One whole period per request; the low phase is long enough for
    // the measurement and its decisions to land before done is raised
    initial
    begin
        o_pin = 1'b0;
        o_done = 1'b0;
        forever
        begin
            @(posedge i_core_clk);
            o_done <= 1'b0;
            if (i_go)
            begin
                o_pin <= 1'b1;
                repeat (i_high_cycles) @(posedge i_core_clk);
                o_pin <= 1'b0;
                repeat (i_low_cycles) @(posedge i_core_clk);
                o_done <= 1'b1;
            end
        end
    end
endmodule : dvtd_cmd_source

/* File: verification/testbench.sv */
// Self-checking bench for duty command target and transition logic
`timescale 1ns/10ps
module testbench
    import dvtd_pkg::*;
;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    typedef struct {
        int kind;
        logic [15:0] exp;
    } dvtd_note_t;

    logic i_core_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic go = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_wait = 1'b0;
    logic chk = 1'b0;
    logic [7:0] cmd = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] hi_c = 16'h0000;
    logic [15:0] fast_c = 16'h0200;
    logic [15:0] slow_c = 16'h0100;
    logic [15:0] min_c = 16'h0080;
    logic [15:0] gain_c = 16'h0200;
    logic [15:0] rdata, tgt, vref, r;
    logic pin, done, ack, act, dn, ddn, dup;
    dvtd_note_t notes[$];
    int n_fail = 0;
    int checked = 0;
    int seed = 66461;
    int i;

    // ----------------------------------------------------------------
    // Design and command source
    // ----------------------------------------------------------------
    dvtd_target_detect i_dut (
        .i_core_clk(i_core_clk), .i_rstn(i_rstn),
        .i_duty_voltage_command(pin), .i_fast_filter_code(fast_c),
        .i_slow_filter_code(slow_c), .i_min_output_code(min_c),
        .i_reg_cmd(cmd), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_ack(ack),
        .o_target_voltage_code(tgt), .o_output_reference(vref),
        .o_transition_active(act), .o_transition_down(dn),
        .o_direction_down(ddn), .o_direction_up(dup));

    dvtd_cmd_source i_src (
        .i_core_clk(i_core_clk), .i_go(go), .i_high_cycles(hi_c),
        .i_low_cycles(16'h0008), .o_pin(pin), .o_done(done));

    always #12.5 i_core_clk = ~i_core_clk;

    // ----------------------------------------------------------------
    // Checking
    // ----------------------------------------------------------------
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    task automatic fail_out(input string what);
        n_fail++;
        $display("ERROR %s expected response seen timeout", what);
        final_report();
    endtask : fail_out

    task automatic cmp_word(input string nm, input logic [15:0] e,
                            input logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_word

    task automatic cmp_flags(input logic [3:0] e, input logic [3:0] g);
        checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR state flags expected %b seen %b", e, g);
        end
    endtask : cmp_flags

    task automatic note(input int kind, input logic [15:0] e);
        notes.push_back('{kind, e});
    endtask : note

    task automatic take;
        dvtd_note_t n;
        n = notes.pop_front();
        case (n.kind)
            0: cmp_word("read data", n.exp, rdata);
            1: cmp_word("target code", n.exp, tgt);
            2: cmp_word("reference", n.exp, vref);
            3: cmp_flags(n.exp[3:0], {act, dn, ddn, dup});
            default: cmp_flags(n.exp[3:0], {act, dn, 2'b00});
        endcase
    endtask : take

    // Oldest note is matched against whatever result appears next
    always @(posedge i_core_clk)
    begin
        // Only this process drives rd_wait: it marks a read strobe last edge
        if (ack === 1'b1 && rd_wait)
            take();
        rd_wait <= rd;
        if (chk)
            while (notes.size() > 0)
                take();
    end

    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    task automatic reg_op(input logic w, input logic [7:0] c,
                          input logic [15:0] d);
        int k;
        cmd <= c;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge i_core_clk);
        wr <= 1'b0;
        rd <= 1'b0;
        for (k = 0; k < 8 && ack !== 1'b1; k++) @(posedge i_core_clk);
        if (ack !== 1'b1) fail_out("register ack");
    endtask : reg_op

    task automatic read(input logic [7:0] c, input logic [15:0] e);
        note(0, e);
        reg_op(1'b0, c, 16'h0000);
    endtask : read

    task automatic check_now;
        chk <= 1'b1;
        @(posedge i_core_clk);
        chk <= 1'b0;
        @(posedge i_core_clk);
    endtask : check_now

    // One command period of n cycles high, then target, reference, flags
    task automatic step(input int n, input logic [15:0] re,
                        input logic [3:0] fe, input bit full);
        int k;
        logic [31:0] t;
        t = ((32'(n) * ONTIME_INC * gain_c) >> GAIN_FRAC) + min_c;
        hi_c <= 16'(n);
        go <= 1'b1;
        @(posedge i_core_clk);
        go <= 1'b0;
        for (k = 0; k < 300 && done !== 1'b1; k++) @(posedge i_core_clk);
        if (done !== 1'b1) fail_out("command period");
        note(1, (t > 32'h0000ffff) ? 16'hffff : t[15:0]);
        note(2, re);
        note(full ? 3 : 4, {12'h000, fe});
        check_now();
    endtask : step

    initial
    begin
        repeat (4) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        @(posedge i_core_clk);
        read(CMD_TRANSITION_CONTROL, RESET_CONTROL);
        read(CMD_GAIN, RESET_GAIN);
        read(CMD_FLOOR, RESET_FLOOR);
        r = 16'($random(seed));
        reg_op(1'b1, CMD_TRANSITION_CONTROL, r);
        read(CMD_TRANSITION_CONTROL, r);
        reg_op(1'b1, CMD_GAIN, 16'hffff);
        read(CMD_GAIN, GAIN_FIELD_MASK);
        r = 16'($random(seed));
        reg_op(1'b1, CMD_FLOOR, r);
        read(CMD_FLOOR, r);
        reg_op(1'b1, 8'ha0, 16'hffff);
        read(8'ha0, 16'h0000);
        reg_op(1'b1, CMD_START_CONTROL, 16'h6884);
        read(CMD_START_CONTROL, 16'h6884);
        // Unity gain: span equals the on-time in 5 ns units
        reg_op(1'b1, CMD_GAIN, gain_c);
        reg_op(1'b1, CMD_TRANSITION_CONTROL, 16'h092d);
        step(20, 16'h0200, 4'b1110, 1'b1);
        step(80, 16'h0100, 4'b0001, 1'b1);
        step(80, 16'h0200, 4'b1001, 1'b1);
        step(25, 16'h0100, 4'b0010, 1'b1);
        // Target inside both start bands: must stay settled
        step(25, 16'h0100, 4'b0010, 1'b1);
        // Input moves inside the hysteresis band; only sync can follow it
        slow_c <= 16'h0101;
        reg_op(1'b1, CMD_TRANSITION_CONTROL, 16'h492d);
        for (i = 0; i < 4500 && vref !== 16'h0101; i++)
            @(posedge i_core_clk);
        if (vref !== 16'h0101) fail_out("sync copy");
        note(2, 16'h0101);
        check_now();
        reg_op(1'b1, CMD_TRANSITION_CONTROL, 16'h892d);
        fast_c <= 16'h0300;
        step(23, 16'h0300, 4'b1100, 1'b0);
        fast_c <= 16'h0000;
        step(23, 16'h0101, 4'b0000, 1'b0);
        step(24, 16'h0101, 4'b0000, 1'b0);
        step(26, 16'h0000, 4'b1000, 1'b0);
        final_report();
    end
endmodule : testbench
